// ---- pkg/mbpm_pkg.sv ----
// Constants and types of the field-point map
package mbpm_pkg;

  // ----------------------------------------------------------------
  // Serial frame format
  // ----------------------------------------------------------------
  localparam int BAUD_RATE = 4800;
  localparam int DATA_BITS = 8;
  localparam int PARITY_BITS = 0;
  localparam int STOP_BITS = 2;
  localparam int CLK_HZ = 125_000_000;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;

  // ----------------------------------------------------------------
  // Accumulator sample timebase, rate counted in tenths of a second
  // ----------------------------------------------------------------
  localparam int TENTH_MS = 100;
  localparam int TENTH_CYCLES = (CLK_HZ / 1000) * TENTH_MS;
  localparam logic [15:0] RATE_RST = 16'h000A;

  // ----------------------------------------------------------------
  // Point address map
  // ----------------------------------------------------------------
  localparam logic [16:0] COIL_BASE = 17'h0_0001;
  localparam logic [16:0] INSTAT_BASE = 17'h0_2711;
  localparam logic [16:0] INREG_BASE = 17'h0_7531;
  localparam logic [16:0] HOLD_BASE = 17'h0_9C41;
  localparam logic [16:0] NUM_COIL_MAX = 17'h0_0010;
  localparam logic [16:0] NUM_INSTAT = 17'h0_0010;
  localparam logic [16:0] NUM_INREG = 17'h0_0008;
  localparam logic [16:0] NUM_HOLD = 17'h0_0004;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [15:0] RAW_MAX = 16'h7FFF;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic [7:0] STATION_RSV = 8'h00;

  typedef enum logic [2:0] {
    MBPM_RGN_NONE,
    MBPM_RGN_COIL,
    MBPM_RGN_INSTAT,
    MBPM_RGN_INREG,
    MBPM_RGN_HOLD
  } mbpm_region_t;

endpackage

// ---- hdl/mbpm_point_map.sv ----
// Field-point map: coils, input status, input and holding registers, accumulators
module mbpm_point_map #(
  parameter int NUM_COIL = 4,
  parameter int NUM_AIN = 8,
  parameter int BIT_CYCLES = mbpm_pkg::BIT_CYCLES,
  parameter int TENTH_CYCLES = mbpm_pkg::TENTH_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] station_addr,
  input wire logic rbe_mode,
  input wire logic status_update,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [16:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [15:0] din_level,
  input wire logic [NUM_AIN*16-1:0] ain_sample,
  input wire logic acc_cfg_valid,
  input wire logic acc_cfg_clear,
  input wire logic [2:0] acc_cfg_chan,
  input wire logic [15:0] acc_cfg_rate,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata,
  output logic station_ok,
  output logic baud_tick,
  output logic [NUM_COIL-1:0] dout,
  output logic [63:0] aout,
  output logic [NUM_AIN*32-1:0] acc_sum,
  output logic [NUM_AIN*32-1:0] acc_count,
  output logic [NUM_AIN*16-1:0] acc_rate
);
  import mbpm_pkg::*;

  localparam int BIT_W = $clog2(BIT_CYCLES);
  localparam int TENTH_W = $clog2(TENTH_CYCLES);
  localparam int CIDX_W = NUM_COIL > 1 ? $clog2(NUM_COIL) : 1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [BIT_W-1:0] bit_cnt_reg;
  logic [TENTH_W-1:0] tenth_cnt_reg;
  logic tenth_tick_reg;
  logic baud_tick_reg;
  logic station_ok_reg;
  logic [NUM_COIL-1:0] coil_reg;
  logic [15:0] hold_reg [4];
  logic [15:0] din_live_reg;
  logic [15:0] din_snap_reg;
  logic [15:0] ain_live_reg [NUM_AIN];
  logic [15:0] ain_snap_reg [NUM_AIN];
  logic rsp_valid_reg;
  logic rsp_err_reg;
  logic [15:0] rsp_rdata_reg;

  // ----------------------------------------------------------------
  // Bit-time tick for the fixed serial frame and tenth-second accumulator tick
  // ----------------------------------------------------------------
  wire bit_wrap = bit_cnt_reg == BIT_W'(BIT_CYCLES - 1);
  wire tenth_wrap = tenth_cnt_reg == TENTH_W'(TENTH_CYCLES - 1);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= '0;
      baud_tick_reg <= 1'b0;
      tenth_cnt_reg <= '0;
      tenth_tick_reg <= 1'b0;
    end else if (clk_en) begin
      bit_cnt_reg <= bit_wrap ? '0 : bit_cnt_reg + 1'b1;
      baud_tick_reg <= bit_wrap;
      tenth_cnt_reg <= tenth_wrap ? '0 : tenth_cnt_reg + 1'b1;
      tenth_tick_reg <= tenth_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [16:0] off_coil = req_addr - COIL_BASE;
  wire [16:0] off_instat = req_addr - INSTAT_BASE;
  wire [16:0] off_inreg = req_addr - INREG_BASE;
  wire [16:0] off_hold = req_addr - HOLD_BASE;
  wire in_coil_rng = req_addr >= COIL_BASE && off_coil < NUM_COIL_MAX;
  wire in_coil = in_coil_rng && off_coil < 17'(NUM_COIL);
  wire in_instat = req_addr >= INSTAT_BASE && off_instat < NUM_INSTAT;
  wire in_inreg = req_addr >= INREG_BASE && off_inreg < 17'(NUM_AIN);
  wire in_hold = req_addr >= HOLD_BASE && off_hold < NUM_HOLD;
  wire [3:0] idx_bit = off_instat[3:0];
  wire [2:0] idx_inreg = off_inreg[2:0];
  wire [1:0] idx_hold = off_hold[1:0];
  wire reachable = station_ok_reg;
  wire req_take = clk_en && req_valid && reachable;
  wire ro_write = req_write && (in_instat || in_inreg);
  wire bad_addr = !(in_coil || in_instat || in_inreg || in_hold);
  wire req_err = bad_addr || ro_write;
  wire coil_we = req_take && req_write && in_coil;
  wire hold_we = req_take && req_write && in_hold;
  wire [15:0] hold_wval = req_wdata[15] ? RAW_MAX : req_wdata;

  // ----------------------------------------------------------------
  // Read selection, live or stored status
  // ----------------------------------------------------------------
  wire [15:0] din_src = rbe_mode ? din_snap_reg : din_live_reg;
  wire [15:0] ain_src = rbe_mode ? ain_snap_reg[idx_inreg] : ain_live_reg[idx_inreg];
  wire [15:0] coil_rd = {15'h0000, coil_reg[off_coil[CIDX_W-1:0]]};
  wire [15:0] instat_rd = {15'h0000, din_src[idx_bit]};
  wire [15:0] rd_data = in_coil ? coil_rd :
                        in_instat ? instat_rd :
                        in_inreg ? ain_src :
                        in_hold ? hold_reg[idx_hold] : 16'h0000;

  // ----------------------------------------------------------------
  // Point storage and answer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      station_ok_reg <= 1'b0;
      coil_reg <= '0;
      rsp_valid_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
      rsp_rdata_reg <= 16'h0000;
      din_live_reg <= 16'h0000;
      din_snap_reg <= 16'h0000;
    end else if (clk_en) begin
      station_ok_reg <= station_addr != STATION_RSV;
      din_live_reg <= ~din_level;
      if (status_update) begin
        din_snap_reg <= ~din_level;
      end
      if (coil_we) begin
        coil_reg[off_coil[CIDX_W-1:0]] <= |req_wdata;
      end
      rsp_valid_reg <= req_valid && reachable;
      rsp_err_reg <= req_valid && reachable && req_err;
      rsp_rdata_reg <= (req_valid && reachable && !req_err && !req_write) ? rd_data : 16'h0000;
    end
  end

  for (genvar h = 0; h < 4; h++) begin : g_hold
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        hold_reg[h] <= HOLD_RST;
      end else if (clk_en && hold_we && idx_hold == 2'(h)) begin
        hold_reg[h] <= hold_wval;
      end
    end
    assign aout[h*16 +: 16] = hold_reg[h];
  end

  // ----------------------------------------------------------------
  // Analog inputs and accumulators
  // ----------------------------------------------------------------
  for (genvar a = 0; a < NUM_AIN; a++) begin : g_ain
    logic [15:0] div_reg;
    logic [15:0] rate_reg;
    logic [31:0] sum_reg;
    logic [31:0] count_reg;
    wire [15:0] raw = ain_sample[a*16 +: 16];
    wire [15:0] clamped = raw[15] ? RAW_MAX : raw;
    wire cfg_hit = acc_cfg_valid && acc_cfg_chan == 3'(a);
    wire hit = tenth_tick_reg && rate_reg != 16'h0000 && div_reg == rate_reg - 16'h0001;

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        ain_live_reg[a] <= 16'h0000;
        ain_snap_reg[a] <= 16'h0000;
      end else if (clk_en) begin
        ain_live_reg[a] <= clamped;
        if (status_update) begin
          ain_snap_reg[a] <= clamped;
        end
      end
    end

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        div_reg <= 16'h0000;
        rate_reg <= RATE_RST;
        sum_reg <= 32'h0000_0000;
        count_reg <= 32'h0000_0000;
      end else if (clk_en) begin
        if (cfg_hit && acc_cfg_clear) begin
          div_reg <= 16'h0000;
          sum_reg <= 32'h0000_0000;
          count_reg <= 32'h0000_0000;
        end else if (tenth_tick_reg) begin
          div_reg <= hit ? 16'h0000 : div_reg + 16'h0001;
          if (hit) begin
            sum_reg <= sum_reg + {16'h0000, clamped};
            count_reg <= count_reg + 32'h0000_0001;
          end
        end
        if (cfg_hit && !acc_cfg_clear) begin
          rate_reg <= acc_cfg_rate;
          div_reg <= 16'h0000;
        end
      end
    end

    assign acc_sum[a*32 +: 32] = sum_reg;
    assign acc_count[a*32 +: 32] = count_reg;
    assign acc_rate[a*16 +: 16] = rate_reg;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid = rsp_valid_reg;
  assign rsp_err = rsp_err_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign station_ok = station_ok_reg;
  assign baud_tick = baud_tick_reg;
  assign dout = coil_reg;

endmodule

// ---- sim/mbpm_point_map_sva.sv ----
// Assertion checker on the point map ports
module mbpm_point_map_sva #(
  parameter int NUM_COIL = 4,
  parameter int NUM_AIN = 8,
  parameter int BIT_CYCLES = 8,
  parameter int TENTH_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] station_addr,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [16:0] req_addr,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata,
  input wire logic station_ok,
  input wire logic baud_tick,
  input wire logic [63:0] aout
);
  import mbpm_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic ro_w, bad_a, seen_reg;
  int gap_reg;
  assign ro_w = req_write && req_addr >= INSTAT_BASE && req_addr < INREG_BASE + NUM_INREG;
  assign bad_a = req_addr < COIL_BASE || req_addr >= HOLD_BASE + NUM_HOLD;
  // Enabled cycles since the last bit tick
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= 0;
      seen_reg <= 1'b0;
    end else if (clk_en) begin
      gap_reg <= baud_tick ? 0 : gap_reg + 1;
      seen_reg <= seen_reg | baud_tick;
    end
  end
  sequence taken_s;
    clk_en && req_valid && station_ok;
  endsequence
  rsp_follows_a: assert property (taken_s |=> rsp_valid) else $error("request not answered");
  rsp_idle_a: assert property (clk_en && !(req_valid && station_ok) |=> !rsp_valid) else $error("stray answer");
  station_ok_a: assert property (clk_en |=> station_ok == ($past(station_addr) != STATION_RSV)) else $error("station");
  ro_write_a: assert property (taken_s ##0 ro_w |=> rsp_err) else $error("read-only write accepted");
  unmapped_a: assert property (taken_s ##0 bad_a |=> rsp_err) else $error("unmapped address accepted");
  raw_range_a: assert property (rsp_valid |-> rsp_rdata <= RAW_MAX) else $error("read value out of range");
  aout_range_a: assert property (!(aout[15] || aout[31] || aout[47] || aout[63])) else $error("analog out range");
  baud_gap_a: assert property (clk_en && seen_reg && baud_tick |-> gap_reg == BIT_CYCLES - 1) else $error("bit time");
endmodule
bind mbpm_point_map mbpm_point_map_sva #(.NUM_COIL(NUM_COIL), .NUM_AIN(NUM_AIN), .BIT_CYCLES(BIT_CYCLES),
  .TENTH_CYCLES(TENTH_CYCLES)) chk (.clock, .rst_b, .clk_en, .station_addr, .req_valid, .req_write, .req_addr,
  .rsp_valid, .rsp_err, .rsp_rdata, .station_ok, .baud_tick, .aout);

// ---- sim/mbpm_master_model.sv ----
// Polling master: one point per poll, timeout and retries
module mbpm_master_model #(
  parameter int TIMEOUT = 6,
  parameter int RETRIES = 2
) (
  input wire logic clock,
  output logic req_valid,
  output logic req_write,
  output logic [16:0] req_addr,
  output logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_valid = 1'b0;
  task automatic poll(input logic w, input logic [16:0] a, input logic [15:0] d, output logic got, output logic err,
    output logic [15:0] rd);
    got = 1'b0;
    err = 1'b0;
    rd = 16'h0000;
    for (int t = 0; t <= RETRIES && !got; t++) begin
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clock);
      req_valid <= 1'b0;
      req_write <= ~w;
      req_addr <= ~a;
      req_wdata <= ~d;
      for (int c = 0; c < TIMEOUT && !got; c++) begin
        @(posedge clock);
        got = rsp_valid === 1'b1;
        err = rsp_err;
        rd = rsp_rdata;
      end
    end
  endtask
endmodule

// ---- sim/mbpm_point_map_test.sv ----
// Self-checking bench for the point map
module mbpm_point_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mbpm_pkg::*;
  logic clock, rst_b, clk_en, rbe_mode, status_update, acc_cfg_valid, acc_cfg_clear, req_valid, req_write, g, ge;
  logic rsp_valid, rsp_err, station_ok, baud_tick;
  logic [2:0] acc_cfg_chan;
  logic [3:0] dout;
  logic [7:0] station_addr;
  logic [15:0] acc_cfg_rate, req_wdata, rsp_rdata, din_level, grd, snap_din;
  logic [16:0] req_addr;
  logic [63:0] aout;
  logic [127:0] ain_sample, snap_ain, acc_rate;
  logic [255:0] acc_sum, acc_count;
  int n_errors, checks_done, cycles, seed, c1, coil[4], hold[4];
  int amap[] = '{0, 1, 4, 5, 16, 17, 10000, 10001, 10016, 10017, 30001, 30008, 30009, 40001, 40004, 40005, 41011};
  mbpm_point_map #(.BIT_CYCLES(8), .TENTH_CYCLES(4)) uut (.clock, .rst_b, .clk_en, .station_addr, .rbe_mode,
    .status_update, .req_valid, .req_write, .req_addr, .req_wdata, .din_level, .ain_sample, .acc_cfg_valid,
    .acc_cfg_clear, .acc_cfg_chan, .acc_cfg_rate, .rsp_valid, .rsp_err, .rsp_rdata, .station_ok, .baud_tick,
    .dout, .aout, .acc_sum, .acc_count, .acc_rate);
  mbpm_master_model master (.clock, .req_valid, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_err, .rsp_rdata);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic int clampv(int v);
    return v > 32767 ? 32767 : v;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic new_inputs();
    din_level <= $random(seed);
    for (int i = 0; i < 8; i++)
      ain_sample[i*16+:16] <= $random(seed);
  endtask
  task automatic cfg(input logic clr, input logic [2:0] ch, input logic [15:0] rate);
    acc_cfg_valid <= 1'b1;
    acc_cfg_clear <= clr;
    acc_cfg_chan <= ch;
    acc_cfg_rate <= rate;
    @(posedge clock);
  endtask
  task automatic do_req(input logic w, input int a, input logic [15:0] d);
    int e;
    int rd;
    logic [15:0] ds;
    logic [127:0] as;
    e = 1;
    rd = 0;
    ds = rbe_mode ? snap_din : din_level;
    as = rbe_mode ? snap_ain : ain_sample;
    if (a >= 1 && a <= 4) begin
      e = 0;
      if (w) coil[a-1] = d != 0;
      rd = w ? 0 : coil[a-1];
    end else if (a >= 10001 && a <= 10016) begin
      e = w;
      rd = w ? 0 : !ds[a-10001];
    end else if (a >= 30001 && a <= 30008) begin
      e = w;
      rd = w ? 0 : clampv(as[(a-30001)*16+:16]);
    end else if (a >= 40001 && a <= 40004) begin
      e = 0;
      if (w) hold[a-40001] = clampv(d);
      rd = w ? 0 : hold[a-40001];
    end
    master.poll(w, a[16:0], d, g, ge, grd);
    check("answer", g, 1);
    check("error", ge, e);
    check("read data", grd, rd);
    for (int i = 0; i < 4; i++) begin
      check("coil", dout[i], coil[i]);
      check("analog out", aout[i*16+:16], hold[i]);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    seed = 32'h411e;
    {rst_b, clk_en, rbe_mode, status_update, acc_cfg_valid, acc_cfg_clear, acc_cfg_chan, acc_cfg_rate} = '0;
    clk_en = 1'b1;
    station_addr = 8'h00;
    new_inputs();
    repeat (12) @(posedge clock);
    for (int i = 0; i < 8; i++)
      check("reset rate", acc_rate[i*16+:16], RATE_RST);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    master.poll(1'b0, 17'h0_0001, 16'h0000, g, ge, grd);
    check("answer at station zero", g, 0);
    $display("test station zero done");
    station_addr <= 8'(({$random(seed)} % 255) + 1);
    repeat (2) @(posedge clock);
    foreach (amap[i])
      do_req(1'b0, amap[i], 16'h0000);
    repeat (80)
      do_req($random(seed), amap[{$random(seed)} % amap.size()], $random(seed));
    $display("test point map done");
    rbe_mode <= 1'b1;
    status_update <= 1'b1;
    @(posedge clock);
    status_update <= 1'b0;
    snap_din = din_level;
    snap_ain = ain_sample;
    new_inputs();
    for (int a = 10001; a <= 30008; a++)
      if (a <= 10016 || a >= 30001) do_req(1'b0, a, 16'h0000);
    rbe_mode <= 1'b0;
    @(posedge clock);
    do_req(1'b0, 10001, 16'h0000);
    do_req(1'b0, 30001, 16'h0000);
    $display("test stored status done");
    cfg(1'b1, 3'd0, 16'h0000);
    cfg(1'b0, 3'd0, 16'h0001);
    cfg(1'b0, 3'd1, 16'h0000);
    acc_cfg_valid <= 1'b0;
    @(posedge clock);
    c1 = acc_count[63:32];
    repeat (40) @(posedge clock);
    check("rates", acc_rate[31:0], 32'h0000_0001);
    check("stopped count", acc_count[63:32], c1);
    check("count range", acc_count[31:0] inside {[9:11]}, 1);
    check("sum", acc_sum[31:0], acc_count[31:0] * clampv(ain_sample[15:0]));
    $display("test accumulator done");
    clk_en <= 1'b0;
    @(posedge clock);
    c1 = acc_count[31:0];
    repeat (20) @(posedge clock);
    check("frozen count", acc_count[31:0], c1);
    $display("test clock enable done");
    close_out();
  end
endmodule
